// file: src/alarm_pkg.sv
// constants and carrier types for the smoke alarm annunciator
package alarm_pkg;
  // clock and time base
  localparam int CLK_HZ        = 40_000_000;
  localparam int SCAN_QUAL_MS  = 3000;   // scan trigger qualification time
  localparam int BLINK_MS      = 500;    // one pattern slot
  localparam int ISOLATE_MS    = 8000;   // remote input hold for isolation
  localparam int SCAN_QUAL_CYC = SCAN_QUAL_MS * (CLK_HZ / 1000);
  localparam int BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);
  localparam int ISOLATE_CYC   = ISOLATE_MS * (CLK_HZ / 1000);
  // sizes
  localparam int NSECT   = 15;  // sampling sectors
  localparam int NLEV    = 5;   // scan, alert, action, third, top
  localparam int SMOKE_W = 16;  // smoke density, 0.001 %obs/m per lsb
  localparam int FLOW_W  = 8;   // raw flow reading
  // level indices
  localparam int LV_SCAN   = 0;
  localparam int LV_ALERT  = 1;
  localparam int LV_ACTION = 2;
  localparam int LV_THIRD  = 3;
  localparam int LV_TOP    = 4;
  // blink period in half-second slots, and the common slot cycle
  localparam logic [4:0] PAT_ALERT  = 5'h05;
  localparam logic [4:0] PAT_ACTION = 5'h03;
  localparam logic [4:0] PAT_THIRD  = 5'h02;
  localparam logic [4:0] SLOT_LAST  = 5'h1D;
  localparam logic [6:0] PCT_FULL   = 7'h64;  // 100 percent
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CMD      = 8'h04;
  localparam logic [7:0] OFF_THR      = 8'h08;  // five level thresholds
  localparam logic [7:0] OFF_FLOW_LIM = 8'h1C;
  localparam logic [7:0] OFF_ACTIVE   = 8'h20;
  localparam logic [7:0] OFF_STATUS   = 8'h24;
  localparam logic [7:0] OFF_ALLTHR   = 8'h28;
  localparam logic [7:0] OFF_SECT_THR = 8'h40;  // per sector third thresholds
  // field positions
  localparam int CTRL_EARLY  = 0;
  localparam int CTRL_ASCAN  = 1;
  localparam int CTRL_LATCH  = 2;  // five bits, one per level
  localparam int CMD_NORM    = 0;
  localparam int CMD_RESET   = 1;
  localparam int FLIM_LOW    = 0;
  localparam int FLIM_HIGH   = 8;
  // reset values
  localparam logic [6:0]  CTRL_RST   = 7'h7C;  // all levels latched
  localparam logic [15:0] THR_SCAN_RST   = 16'h001E;
  localparam logic [15:0] THR_ALERT_RST  = 16'h0028;
  localparam logic [15:0] THR_ACTION_RST = 16'h003C;
  localparam logic [15:0] THR_THIRD_RST  = 16'h0050;
  localparam logic [15:0] THR_TOP_RST    = 16'h03E8;
  localparam logic [15:0] FLIM_RST       = 16'h9632;  // high 150, low 50
  localparam logic [14:0] ACTIVE_RST     = 15'h7FFF;
  // relay bundle
  typedef struct packed {
    logic top;
    logic third;
    logic action;
    logic alert;
    logic fault;
  } relay_t;
  // panel fault and status lamps
  typedef struct packed {
    logic general;
    logic power;
    logic comms;
    logic flow;
    logic isolated;
    logic hold;
  } lamp_t;
endpackage

// file: src/smoke_alarm_annunciator.sv
// alarm evaluation, latching and annunciation for an aspirating smoke detector
`timescale 1ns/10ps
module smoke_alarm_annunciator #(
  parameter int SCAN_QUAL_CYC = alarm_pkg::SCAN_QUAL_CYC,
  parameter int BLINK_CYC     = alarm_pkg::BLINK_CYC,
  parameter int ISOLATE_CYC   = alarm_pkg::ISOLATE_CYC
) (
  // clock and reset
  input  wire logic                                        clk,
  input  wire logic                                        rstn,
  // register port
  input  wire logic [7:0]                                  addr,
  input  wire logic [31:0]                                 wdata,
  input  wire logic                                        wr,
  input  wire logic                                        rd,
  output logic [31:0]                                      rdata,
  // measurement front end, same clock
  input  wire logic [alarm_pkg::SMOKE_W-1:0]               smoke,
  input  wire logic [alarm_pkg::NSECT*alarm_pkg::FLOW_W-1:0] flow,
  input  wire logic [3:0]                                  scan_pos,
  input  wire logic                                        scan_done,
  input  wire logic                                        manual_scan,
  // pins from outside, synchronised here
  input  wire logic                                        remote_in,
  input  wire logic                                        proc_fail,
  input  wire logic [3:0]                                  hw_fault,
  input  wire logic                                        comms_fault,
  // relays, sounder, beacon and lamps
  output alarm_pkg::relay_t                                relay,
  output logic                                             sounder,
  output logic                                             beacon,
  output logic [alarm_pkg::NLEV-1:0]                       level_lamp,
  output logic [alarm_pkg::NSECT-1:0]                      sector_lamp,
  output alarm_pkg::lamp_t                                 lamp
);
  localparam int NS = alarm_pkg::NSECT;
  localparam int NL = alarm_pkg::NLEV;
  localparam int QW = $clog2(SCAN_QUAL_CYC + 1);
  localparam int BW = $clog2(BLINK_CYC + 1);
  localparam int IW = $clog2(ISOLATE_CYC + 1);

  typedef enum logic {ST_IDLE, ST_SCAN} scan_st_t;

  // software state
  logic [6:0]  ctrl_reg;                 // early, alert-from-scan, latch mask
  logic [15:0] thr_reg [NL];             // level thresholds
  logic [15:0] sect_thr_reg [NS];        // per sector third thresholds
  logic [15:0] flim_reg;                 // flow limits in percent
  logic [14:0] active_reg;               // active sector mask
  // alarm state
  logic [NL-1:0] lvl_reg;                // global alarm levels
  logic [QW-1:0] qual_reg;               // scan qualification timer
  scan_st_t      st_reg;                 // scan mode
  logic [2:0]    deg_reg [NS];           // highest degree seen per sector
  logic [7:0]    ref_reg [NS];           // normalized flow references
  // timers
  logic [BW-1:0] blink_reg;
  logic [4:0]    slot_reg;               // half-second slot 0..29
  logic [IW-1:0] iso_reg;                // remote input hold time
  logic          remote_prev_reg;
  // two-flop synchronisers for the pins
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;

  // decode
  wire wr_ctrl   = wr && addr == alarm_pkg::OFF_CTRL;
  wire wr_cmd    = wr && addr == alarm_pkg::OFF_CMD;
  wire wr_flim   = wr && addr == alarm_pkg::OFF_FLOW_LIM;
  wire wr_active = wr && addr == alarm_pkg::OFF_ACTIVE;
  wire normalize = wr_cmd && wdata[alarm_pkg::CMD_NORM];

  // synchronised pins
  wire       remote_s  = sync2_reg[0];
  wire       procf_s   = sync2_reg[1];
  wire       comms_s   = sync2_reg[2];
  wire [3:0] hwf_s     = sync2_reg[6:3];

  // remote input: long hold isolates, short press resets
  wire iso_full    = iso_reg == IW'(ISOLATE_CYC);
  wire isolated    = remote_s && iso_full;
  wire remote_rst  = remote_prev_reg && !remote_s && !iso_full;
  wire user_rst    = (wr_cmd && wdata[alarm_pkg::CMD_RESET]) || remote_rst;

  // level comparisons against the global smoke reading
  wire overall = scan_pos == 4'h0;
  logic [NL-1:0] above;
  logic [NL-1:0] trig;
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_cmp
      assign above[g] = smoke > thr_reg[g];
    end
  endgenerate

  // diluted all-sector threshold: running minimum and active count
  logic [15:0] min_w [NS+1];
  logic [3:0]  cnt_w [NS+1];
  assign min_w[0] = 16'hFFFF;
  assign cnt_w[0] = 4'h0;
  generate
    for (g = 0; g < NS; g++) begin : g_dil
      wire take = active_reg[g] && sect_thr_reg[g] < min_w[g];
      assign min_w[g+1] = take ? sect_thr_reg[g] : min_w[g];
      assign cnt_w[g+1] = cnt_w[g] + 4'(active_reg[g]);
    end
  endgenerate
  wire [15:0] diluted = (cnt_w[NS] == 4'h0) ? thr_reg[alarm_pkg::LV_SCAN]
                        : min_w[NS] / 16'(cnt_w[NS]);
  // the lower of the two is the more sensitive one and is used
  wire [15:0] all_thr = (diluted > thr_reg[alarm_pkg::LV_SCAN])
                        ? thr_reg[alarm_pkg::LV_SCAN]
                        : diluted;
  wire early_hit = ctrl_reg[alarm_pkg::CTRL_EARLY] && overall && smoke > all_thr;

  // triggers; scan only qualifies in the combined intake position
  wire scan_cond = overall && above[alarm_pkg::LV_SCAN];
  wire scan_q    = scan_cond && qual_reg == QW'(SCAN_QUAL_CYC);
  assign trig = {above[alarm_pkg::LV_TOP], above[alarm_pkg::LV_THIRD] | early_hit,
                 above[alarm_pkg::LV_ACTION], above[alarm_pkg::LV_ALERT], scan_q};
  // latch: the trigger sets and wins over a clear in the same cycle
  wire [NL-1:0] latch = ctrl_reg[alarm_pkg::CTRL_LATCH +: NL];
  wire [NL-1:0] lvl_next = trig | (lvl_reg & latch & {NL{!user_rst}});

  // degree of the current global alarm, 0 none .. 4 top
  wire [2:0] cur_deg = lvl_reg[alarm_pkg::LV_TOP]    ? 3'h4 :
                       lvl_reg[alarm_pkg::LV_THIRD]  ? 3'h3 :
                       lvl_reg[alarm_pkg::LV_ACTION] ? 3'h2 :
                       lvl_reg[alarm_pkg::LV_ALERT]  ? 3'h1 : 3'h0;

  // blink pattern for a degree in the current half-second slot
  function automatic logic pattern(input logic [2:0] d, input logic [4:0] s);
    unique case (d)
      3'h4:    pattern = 1'b1;
      3'h3:    pattern = (s % alarm_pkg::PAT_THIRD) == 5'h00;
      3'h2:    pattern = (s % alarm_pkg::PAT_ACTION) == 5'h00;
      3'h1:    pattern = (s % alarm_pkg::PAT_ALERT) == 5'h00;
      default: pattern = 1'b0;
    endcase
  endfunction

  // flow check per sector against its normalized reference
  logic [NS-1:0] flow_bad;
  generate
    for (g = 0; g < NS; g++) begin : g_flow
      wire [7:0]  fv  = flow[g*alarm_pkg::FLOW_W +: alarm_pkg::FLOW_W];
      wire [15:0] pct = 16'(fv) * 16'(alarm_pkg::PCT_FULL);
      wire [15:0] hi  = 16'(ref_reg[g]) * 16'(flim_reg[alarm_pkg::FLIM_HIGH +: 8]);
      wire [15:0] lo  = 16'(ref_reg[g]) * 16'(flim_reg[alarm_pkg::FLIM_LOW +: 8]);
      assign flow_bad[g] = active_reg[g] && (pct > hi || pct < lo);

      // reference capture and sector degree while scanning
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ref_reg[g] <= 8'h00;
          deg_reg[g] <= 3'h0;
        end else begin
          if (normalize)
            ref_reg[g] <= fv;
          if (st_reg == ST_IDLE)
            deg_reg[g] <= 3'h0;
          else if (scan_pos == 4'(g + 1) && cur_deg > deg_reg[g])
            deg_reg[g] <= cur_deg;
        end
      end

      // per sector third threshold register
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
          sect_thr_reg[g] <= alarm_pkg::THR_THIRD_RST;
        else if (wr && addr == 8'(alarm_pkg::OFF_SECT_THR + 4 * g))
          sect_thr_reg[g] <= wdata[15:0];
      end
    end
    // level threshold registers
    for (g = 0; g < NL; g++) begin : g_thr
      localparam logic [15:0] RV = (g == 0) ? alarm_pkg::THR_SCAN_RST :
                                   (g == 1) ? alarm_pkg::THR_ALERT_RST :
                                   (g == 2) ? alarm_pkg::THR_ACTION_RST :
                                   (g == 3) ? alarm_pkg::THR_THIRD_RST : alarm_pkg::THR_TOP_RST;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
          thr_reg[g] <= RV;
        else if (wr && addr == 8'(alarm_pkg::OFF_THR + 4 * g))
          thr_reg[g] <= wdata[15:0];
      end
    end
  endgenerate

  // read selection
  wire [31:0] status = {8'h00, 1'b0, flow_bad[NS-1:0], isolated, |flow_bad,
                        st_reg == ST_SCAN, lvl_reg};
  logic [31:0] rd_sel;
  always_comb begin
    rd_sel = 32'h0000_0000;  // unmapped reads return zero
    unique case (addr)
      alarm_pkg::OFF_CTRL:     rd_sel = 32'(ctrl_reg);
      alarm_pkg::OFF_FLOW_LIM: rd_sel = 32'(flim_reg);
      alarm_pkg::OFF_ACTIVE:   rd_sel = 32'(active_reg);
      alarm_pkg::OFF_STATUS:   rd_sel = status;
      alarm_pkg::OFF_ALLTHR:   rd_sel = 32'(all_thr);
      default: begin
        for (int i = 0; i < NL; i++)
          if (addr == 8'(alarm_pkg::OFF_THR + 4 * i)) rd_sel = 32'(thr_reg[i]);
        for (int i = 0; i < NS; i++)
          if (addr == 8'(alarm_pkg::OFF_SECT_THR + 4 * i)) rd_sel = 32'(sect_thr_reg[i]);
      end
    endcase
  end

  // control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= alarm_pkg::CTRL_RST;
      flim_reg   <= alarm_pkg::FLIM_RST;
      active_reg <= alarm_pkg::ACTIVE_RST;
    end else begin
      if (wr_ctrl)   ctrl_reg   <= wdata[6:0];
      if (wr_flim)   flim_reg   <= wdata[15:0];
      if (wr_active) active_reg <= wdata[14:0];
    end
  end

  // synchronisers and remote input timing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg       <= 7'h00;
      sync2_reg       <= 7'h00;
      iso_reg         <= '0;
      remote_prev_reg <= 1'b0;
    end else begin
      sync1_reg       <= {hw_fault, comms_fault, proc_fail, remote_in};
      sync2_reg       <= sync1_reg;
      remote_prev_reg <= remote_s;
      if (!remote_s)    iso_reg <= '0;
      else if (!iso_full) iso_reg <= iso_reg + IW'(1);
    end
  end

  // alarm levels, scan qualification and scan mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_reg  <= '0;
      qual_reg <= '0;
      st_reg   <= ST_IDLE;
    end else begin
      lvl_reg <= lvl_next;
      // restart the timer whenever smoke drops or the valve leaves overall
      if (!scan_cond)               qual_reg <= '0;
      else if (!scan_q)             qual_reg <= qual_reg + QW'(1);
      unique case (st_reg)
        ST_IDLE: if (scan_q) st_reg <= ST_SCAN;
        ST_SCAN: if (scan_done && !above[alarm_pkg::LV_SCAN]) st_reg <= ST_IDLE;
      endcase
    end
  end

  // half-second slot timer shared by beacon, sector lamps and hold lamp
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_reg <= '0;
      slot_reg  <= 5'h00;
    end else if (blink_reg == BW'(BLINK_CYC - 1)) begin
      blink_reg <= '0;
      slot_reg  <= (slot_reg == alarm_pkg::SLOT_LAST) ? 5'h00 : slot_reg + 5'h01;
    end else begin
      blink_reg <= blink_reg + BW'(1);
    end
  end

  // outputs, each from a flop
  wire alert_src = ctrl_reg[alarm_pkg::CTRL_ASCAN] ? lvl_reg[alarm_pkg::LV_SCAN]
                                                   : lvl_reg[alarm_pkg::LV_ALERT];
  wire gen_fault = |hwf_s || comms_s || procf_s || |flow_bad || isolated;
  logic [NS-1:0] sect_next;
  generate
    for (g = 0; g < NS; g++) begin : g_sect
      assign sect_next[g] = st_reg == ST_SCAN && pattern(deg_reg[g], slot_reg);
    end
  endgenerate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      relay       <= '0;
      sounder     <= 1'b0;
      beacon      <= 1'b0;
      level_lamp  <= '0;
      sector_lamp <= '0;
      lamp        <= '0;
      rdata       <= 32'h0000_0000;
    end else begin
      relay.alert    <= alert_src && !isolated;
      relay.action   <= lvl_reg[alarm_pkg::LV_ACTION] && !isolated;
      relay.third    <= lvl_reg[alarm_pkg::LV_THIRD] && !isolated;
      relay.top      <= lvl_reg[alarm_pkg::LV_TOP] && !isolated;
      relay.fault    <= gen_fault;
      sounder        <= |lvl_reg;
      beacon         <= pattern(cur_deg, slot_reg);
      level_lamp     <= lvl_reg;
      sector_lamp    <= sect_next;
      lamp.general   <= gen_fault;
      lamp.power     <= 1'b1;
      lamp.comms     <= comms_s || procf_s;
      lamp.flow      <= |flow_bad;
      lamp.isolated  <= isolated;
      lamp.hold      <= manual_scan && !slot_reg[0];
      rdata          <= rd ? rd_sel : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  flow_lamp_a: assert property (|flow_bad |=> lamp.flow) else $error("flow fault lamp missed");
  norm_ref_a: assert property (normalize |=> ref_reg[0] == $past(flow[7:0]))
    else $error("flow reference not captured");
  scan_qual_a: assert property (trig[0] |-> $past(scan_cond, 1) && overall)
    else $error("scan trigger without qualification");
  unlatch_a: assert property (!latch[1] && !trig[1] |=> !lvl_reg[1])
    else $error("unlatched alert held");
  latch_hold_a: assert property (latch[2] && lvl_reg[2] && !user_rst |=> lvl_reg[2])
    else $error("latched action dropped");
  scan_exit_a: assert property (st_reg == ST_SCAN && scan_done && !above[0] |=> st_reg == ST_IDLE)
    else $error("scan mode not left");
  early_off_a: assert property (!ctrl_reg[0] && !above[3] |-> !trig[3])
    else $error("all-sector alarm while disabled");
  iso_relay_a: assert property (isolated |=> !relay.top && !relay.third && !relay.action && !relay.alert)
    else $error("relay active while isolated");
  proc_lamps_a: assert property (procf_s |=> lamp.general && lamp.power && lamp.comms)
    else $error("processor failure lamps missing");
  fault_mirror_a: assert property (relay.fault == lamp.general)
    else $error("fault relay differs from lamp");
  reset_clear_a: assert property (user_rst && !trig[2] |=> !lvl_reg[2])
    else $error("latched level survived reset");
endmodule // smoke_alarm_annunciator

// file: dv/front_end_model.sv
// behavioural measurement front end that feeds the annunciator
`timescale 1ns/10ps
module front_end_model (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // requests from the bench
  input  wire logic [15:0]  smoke_req,
  input  wire logic [7:0]   flow_req,
  input  wire logic [3:0]   pos_req,
  input  wire logic         done_req,
  input  wire logic         man_req,
  // readings towards the block
  output logic [15:0]       smoke,
  output logic [119:0]      flow,
  output logic [3:0]        scan_pos,
  output logic              scan_done,
  output logic              manual_scan
);
  // readings land one edge after a request, like a sampled converter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smoke <= 16'h0000;
      flow <= 120'h0;
      scan_pos <= 4'h0;
      scan_done <= 1'b0;
      manual_scan <= 1'b0;
    end else begin
      smoke <= smoke_req;
      // sector 0 follows the request, the others sit at a steady 100
      flow <= {{14{8'h64}}, flow_req};
      scan_pos <= pos_req;
      // end of scan is high on every other edge for as long as the request stays
      scan_done <= done_req && !scan_done;
      manual_scan <= man_req;
    end
  end
endmodule // front_end_model

// file: dv/smoke_alarm_annunciator_test.sv
// self-checking bench for the smoke alarm annunciator
`timescale 1ns/10ps
module smoke_alarm_annunciator_test;
  // stimulus, all defined at time zero
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, done_req = 1'b0, man_req = 1'b0;
  logic remote_in = 1'b0, proc_fail = 1'b0, rd_d = 1'b0;
  logic [7:0] addr = 8'h00, flow_req = 8'h64;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] smoke_req = 16'h0000, smoke;
  logic [3:0] pos_req = 4'h1, scan_pos;
  // design side
  logic [119:0] flow;
  logic scan_done, manual_scan, sounder, beacon;
  logic [4:0] level_lamp;
  logic [14:0] sector_lamp;
  alarm_pkg::relay_t relay;
  alarm_pkg::lamp_t lamp;
  logic [31:0] exp_q[$];  // read results still owed by the block
  logic [31:0] thr[5] = '{32'h1E, 32'h28, 32'h3C, 32'h50, 32'h3E8};
  int err_count = 0, total_checks = 0, seed = 26, ones = 0, blinks = 0;

  always #12.5 clk = ~clk;

  front_end_model i_fe (.clk(clk), .rstn(rstn), .smoke_req(smoke_req), .flow_req(flow_req), .pos_req(pos_req),
    .done_req(done_req), .man_req(man_req), .smoke(smoke), .flow(flow), .scan_pos(scan_pos),
    .scan_done(scan_done), .manual_scan(manual_scan));
  // short counts keep the run brief; waits below are derived from them
  smoke_alarm_annunciator #(.SCAN_QUAL_CYC(8), .BLINK_CYC(4), .ISOLATE_CYC(16)) i_dut (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .smoke(smoke), .flow(flow), .scan_pos(scan_pos),
    .scan_done(scan_done), .manual_scan(manual_scan), .remote_in(remote_in), .proc_fail(proc_fail),
    .hw_fault(4'h0), .comms_fault(1'b0), .relay(relay), .sounder(sounder), .beacon(beacon),
    .level_lamp(level_lamp), .sector_lamp(sector_lamp), .lamp(lamp));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // the expected word is noted before the strobe goes out
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // settle point: n edges, then look at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic drive(input logic [15:0] s, input logic [3:0] p);
    @(posedge clk);
    smoke_req <= s;
    pos_req <= p;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // read data stand one cycle only, so they are taken mid-cycle
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), rdata);
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(8'h00, 32'h7C);
    for (int i = 0; i < 5; i++) rd_reg(8'(8'h08 + 4 * i), thr[i]);
    rd_reg(8'h04, 32'h0);
    rd_reg(8'hFC, 32'h0);
    $display("test reset_values done");
    wr_reg(8'h04, 32'h1);
    @(posedge clk);
    flow_req <= 8'h96;
    cyc(5);
    chk("flow at limit", 1'b0, lamp.flow);
    @(posedge clk);
    flow_req <= 8'h97;
    cyc(5);
    chk("flow above limit", 1'b1, lamp.flow);
    chk("fault relay", 2'b11, {relay.fault, lamp.general});
    wr_reg(8'h04, 32'h1);
    cyc(5);
    chk("flow renormalized", 1'b0, lamp.flow);
    $display("test flow done");
    wr_reg(8'h00, 32'h74);
    drive(16'(41 + {$random(seed)} % 19), 4'h1);
    cyc(4);
    chk("alert relay", 1'b1, relay.alert);
    chk("sounder", 1'b1, sounder);
    drive(16'h0028, 4'h1);
    cyc(4);
    chk("alert cleared", 2'b00, {relay.alert, sounder});
    drive(16'h003D, 4'h1);
    cyc(4);
    drive(16'h0000, 4'h1);
    cyc(4);
    chk("action held", 1'b1, relay.action);
    chk("scan off sector", 1'b0, level_lamp[0]);
    wr_reg(8'h04, 32'h2);
    cyc(2);
    chk("action reset", 1'b0, relay.action);
    $display("test latching done");
    wr_reg(8'h00, 32'h76);  // alert relay now follows the scan level
    drive(16'h001F, 4'h0);
    cyc(6);
    chk("scan early", 1'b0, level_lamp[0]);
    cyc(8);
    rd_reg(8'h24, 32'h21);
    // action smoke while the valve sits on the second sector
    drive(16'h003D, 4'h2);
    cyc(4);
    // 24 cycles are two whole action periods of three 4-cycle slots
    for (int i = 0; i < 24; i++) begin
      cyc(1);
      ones += sector_lamp[1];
      blinks += beacon;
    end
    chk("sector blink", 8, ones);
    chk("action beacon", 8, blinks);
    chk("other sectors", 15'h0000, sector_lamp & 15'h7FFD);
    ones = 0;
    drive(16'h0000, 4'h0);
    @(posedge clk);
    done_req <= 1'b1;
    @(posedge clk);
    done_req <= 1'b0;
    cyc(4);
    chk("scan lamp held", 1'b1, level_lamp[0]);
    chk("alert from scan", 1'b1, relay.alert);
    rd_reg(8'h24, 32'h05);
    wr_reg(8'h04, 32'h2);
    cyc(2);
    chk("alert follows scan", 1'b0, relay.alert);
    $display("test scan done");
    rd_reg(8'h28, 32'h5);
    drive(16'h0006, 4'h0);
    cyc(4);
    chk("no all-sector", 1'b0, level_lamp[3]);
    wr_reg(8'h00, 32'h75);
    cyc(4);
    chk("all-sector third", 1'b1, level_lamp[3]);
    drive(16'h0000, 4'h1);
    wr_reg(8'h20, 32'h3);
    rd_reg(8'h28, 32'h1E);
    wr_reg(8'h04, 32'h2);
    $display("test early done");
    @(posedge clk);
    proc_fail <= 1'b1;
    cyc(5);
    chk("cpu fail lamps", 3'b111, {lamp.general, lamp.power, lamp.comms});
    @(posedge clk);
    proc_fail <= 1'b0;
    remote_in <= 1'b1;
    drive(16'h003D, 4'h1);
    cyc(24);
    chk("isolated lamps", 2'b11, {lamp.isolated, lamp.general});
    chk("relay suppressed", 2'b01, {relay.action, level_lamp[2]});
    @(posedge clk);
    remote_in <= 1'b0;
    drive(16'h03E9, 4'h1);
    cyc(6);
    chk("relay back", 1'b1, relay.action);
    @(posedge clk);
    man_req <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      chk("top beacon", 1'b1, beacon);
      ones += lamp.hold;
    end
    chk("hold flashes", 1'b1, ones > 0 && ones < 16);
    $display("test outputs done");
    stop_test();
  end
endmodule // smoke_alarm_annunciator_test
